// file: svm_pkg.sv
// package of the supply voltage monitor control block
// assumes one 50 MHz clock and an 8-bit register port with 4-bit address
package svm_pkg;
   // clock and settle timing
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned SETTLE_TIME_NS = 20000;
   // least settle time rounds up to whole cycles
   localparam int unsigned SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_W = 10;
   localparam logic [9:0] SETTLE_LAST = 10'(SETTLE_CYCLES - 1);

   // register port widths and offsets
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;
   localparam logic [3:0] OFS_CLEAR = 4'h2;
   localparam logic [3:0] OFS_IRQ_EN = 4'h3;

   // control register fields
   localparam int unsigned LIMIT_LSB = 0;
   localparam int unsigned LIMIT_W = 4;
   localparam int unsigned POWER_BIT = 4;
   localparam int unsigned STABLE_BIT = 5;
   localparam logic [3:0] LIMIT_RESET = 4'h5;
   localparam logic [3:0] LIMIT_EXTERNAL = 4'hF;
   localparam logic [3:0] LIMIT_RESERVED = 4'h0;
   localparam logic [1:0] UNUSED_TOP = 2'h0;

   // status, clear and enable layout
   localparam int unsigned EV_W = 2;
   localparam int unsigned EV_LOW_BIT = 0;
   localparam int unsigned EV_READY_BIT = 1;
   localparam logic [1:0] EV_NONE = 2'h0;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } svm_bus_req_t;

   typedef struct packed {
      logic power;
      logic ext_sel;
      logic [3:0] tap;
   } svm_analog_t;

   typedef enum logic [1:0] {
      SVM_OFF,
      SVM_SETTLING,
      SVM_ARMED
   } svm_state_t;
endpackage

// file: svm_sticky.sv
// sticky event bits, one per lane, set by hardware and cleared by software
// assumes set and clear are one-cycle pulses on mclk
module svm_sticky #(
   parameter int unsigned W = 2
) (
   input wire logic mclk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic [W-1:0] set, // event pulses
   input wire logic [W-1:0] clr, // software clear pulses
   output logic [W-1:0] q // sticky bits
);
   typedef struct packed {
      logic [W-1:0] bits;
   } svm_sticky_st_t;

   svm_sticky_st_t st;
   svm_sticky_st_t next_st;

   // a set in the clear cycle wins so no event is lost
   always_comb begin
      next_st = st;
      next_st.bits = (st.bits & ~clr) | set;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.bits;
endmodule

// file: svm_settle_timer.sv
// settle timer: models the reference start-up delay after power-up
// assumes enable is the registered power bit of the control register
module svm_settle_timer (
   input wire logic mclk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic enable, // detector powered
   output logic stable // reference settled
);
   typedef struct packed {
      logic [svm_pkg::SETTLE_W-1:0] cnt;
      logic stable;
   } svm_timer_st_t;

   svm_timer_st_t st;
   svm_timer_st_t next_st;

   // restart from zero on every enable, drop at once on disable
   always_comb begin
      next_st = st;
      if (!enable) begin
         next_st.cnt = '0;
         next_st.stable = 1'b0;
      end else if (!st.stable) begin
         if (st.cnt == svm_pkg::SETTLE_LAST) begin
            next_st.stable = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 10'h001;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign stable = st.stable;
endmodule

// file: svm_ctrl.sv
// control and flag logic of the supply voltage monitor
// assumes cmp_below and in_sleep are synchronous to mclk
// the divider, reference and comparator live outside on the analog side
//
// The strobed register port and the register offsets are this design's own decisions.
module svm_ctrl (
   input wire logic mclk, // system clock, 50 MHz
   input wire logic nrst, // async reset, active low
   input wire svm_pkg::svm_bus_req_t bus_req, // register request
   output logic [7:0] rdata, // read data, cycle after read strobe
   input wire logic cmp_below, // comparator: tap below reference
   input wire logic in_sleep, // device is asleep
   output svm_pkg::svm_analog_t analog, // divider tap and power controls
   output logic wake, // wake request while asleep
   output logic irq // level interrupt
);
   typedef struct packed {
      logic [3:0] limit;
      logic power;
      logic [1:0] irq_en;
      svm_pkg::svm_state_t state;
      logic stable_d;
      logic [7:0] rdata;
      svm_pkg::svm_analog_t analog;
      logic wake;
      logic irq;
   } svm_ctrl_st_t;

   svm_ctrl_st_t st;
   svm_ctrl_st_t next_st;

   logic stable;
   logic [1:0] status;
   logic [1:0] ev_set;
   logic [1:0] ev_clr;
   logic lv_event;
   logic ready_event;
   logic wr_ctrl;
   logic wr_clear;
   logic wr_irq_en;
   logic rd_hit;

   // reference settle model, restarted by every power-up
   svm_settle_timer u_settle (
      .mclk(mclk),
      .nrst(nrst),
      .enable(st.power),
      .stable(stable)
   );

   // sticky status bits with set winning over clear
   svm_sticky #(
      .W(svm_pkg::EV_W)
   ) u_status (
      .mclk(mclk),
      .nrst(nrst),
      .set(ev_set),
      .clr(ev_clr),
      .q(status)
   );

   // write decode; strobes are single-cycle and never together
   always_comb begin
      wr_ctrl = bus_req.wr && (bus_req.addr == svm_pkg::OFS_CTRL);
      wr_clear = bus_req.wr && (bus_req.addr == svm_pkg::OFS_CLEAR);
      wr_irq_en = bus_req.wr && (bus_req.addr == svm_pkg::OFS_IRQ_EN);
      rd_hit = bus_req.rd;
   end

   // comparator only counts once armed, so a false trip while settling is hidden
   always_comb begin
      lv_event = (st.state == svm_pkg::SVM_ARMED) && stable && cmp_below;
      ready_event = stable && !st.stable_d;
      ev_set = svm_pkg::EV_NONE;
      ev_set[svm_pkg::EV_LOW_BIT] = lv_event;
      ev_set[svm_pkg::EV_READY_BIT] = ready_event;
      ev_clr = wr_clear ? bus_req.wdata[1:0] : svm_pkg::EV_NONE;
   end

   // all state moves here; outputs are copies taken from registers
   always_comb begin
      next_st = st;
      next_st.stable_d = stable;

      // control register: only limit and power are writable
      if (wr_ctrl) begin
         next_st.limit = bus_req.wdata[svm_pkg::LIMIT_LSB +: svm_pkg::LIMIT_W];
         next_st.power = bus_req.wdata[svm_pkg::POWER_BIT];
      end
      if (wr_irq_en) begin
         next_st.irq_en = bus_req.wdata[1:0];
      end

      // detector sequence follows the power bit and the settle model
      case (st.state)
         svm_pkg::SVM_OFF: begin
            if (st.power) begin
               next_st.state = svm_pkg::SVM_SETTLING;
            end
         end
         svm_pkg::SVM_SETTLING: begin
            if (!st.power) begin
               next_st.state = svm_pkg::SVM_OFF;
            end else if (stable) begin
               next_st.state = svm_pkg::SVM_ARMED;
            end
         end
         svm_pkg::SVM_ARMED: begin
            if (!st.power) begin
               next_st.state = svm_pkg::SVM_OFF;
            end
         end
         default: begin
            next_st.state = svm_pkg::SVM_OFF;
         end
      endcase

      // tap select; code 0 is passed on as is, software must avoid it
      next_st.analog.power = st.power;
      next_st.analog.ext_sel = (st.limit == svm_pkg::LIMIT_EXTERNAL);
      next_st.analog.tap = (st.limit == svm_pkg::LIMIT_EXTERNAL) ?
         svm_pkg::LIMIT_RESERVED : st.limit;

      // wake holds until the device leaves sleep
      next_st.wake = in_sleep && (lv_event || st.wake);

      // level interrupt, one cycle behind the status bits
      next_st.irq = |(status & st.irq_en);

      // read mux; clear register is write-only and reads as zero
      next_st.rdata = 8'h00;
      if (rd_hit) begin
         case (bus_req.addr)
            svm_pkg::OFS_CTRL: begin
               next_st.rdata = {svm_pkg::UNUSED_TOP, stable && st.power, st.power,
                  st.limit};
            end
            svm_pkg::OFS_STATUS: begin
               next_st.rdata = {6'h00, status};
            end
            svm_pkg::OFS_IRQ_EN: begin
               next_st.rdata = {6'h00, st.irq_en};
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
   end

   // reset leaves the detector unpowered with the default limit
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st.limit <= svm_pkg::LIMIT_RESET;
         st.power <= 1'b0;
         st.irq_en <= svm_pkg::EV_NONE;
         st.state <= svm_pkg::SVM_OFF;
         st.stable_d <= 1'b0;
         st.rdata <= 8'h00;
         st.analog <= '0;
         st.wake <= 1'b0;
         st.irq <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign analog = st.analog;
   assign wake = st.wake;
   assign irq = st.irq;

   // checks on the block's own behaviour
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   a_flag_sets: assert property (lv_event |=> status[svm_pkg::EV_LOW_BIT])
      else $error("low voltage event did not set the flag");

   a_limit_to_tap: assert property (
      wr_ctrl && (bus_req.wdata[3:0] != svm_pkg::LIMIT_EXTERNAL)
      |=> ##1 (analog.tap == $past(bus_req.wdata[3:0], 2)) && !analog.ext_sel)
      else $error("tap does not follow the written limit");

   a_ext_select: assert property (
      wr_ctrl && (bus_req.wdata[3:0] == svm_pkg::LIMIT_EXTERNAL)
      |=> ##1 analog.ext_sel)
      else $error("external input not selected for limit all ones");

   a_power_follow: assert property (
      wr_ctrl |=> ##1 (analog.power == $past(bus_req.wdata[svm_pkg::POWER_BIT], 2)))
      else $error("power output does not follow control bit");

   a_stable_read: assert property (
      rd_hit && (bus_req.addr == svm_pkg::OFS_CTRL)
      |=> rdata[svm_pkg::STABLE_BIT] == $past(stable && st.power))
      else $error("stable bit read back wrong");

   a_top_zero: assert property (
      rd_hit && (bus_req.addr == svm_pkg::OFS_CTRL) |=> rdata[7:6] == 2'h0)
      else $error("unused control bits read nonzero");

   // watched at the sticky bit, so a broken gate upstream shows here
   a_no_early_flag: assert property (
      $rose(status[svm_pkg::EV_LOW_BIT]) |-> $past(stable))
      else $error("flag raised before reference stable");

   a_sleep_wake: assert property (in_sleep && lv_event |=> wake)
      else $error("crossing in sleep did not wake");

   a_settle_min: assert property (
      $rose(st.power) |-> !stable [*8])
      else $error("stable flag came too early");

   a_stable_drop: assert property ($fell(st.power) |-> ##1 !stable)
      else $error("stable flag not cleared on disable");

   c_trip: cover property (lv_event && st.irq_en[svm_pkg::EV_LOW_BIT]);
   c_sleep_wake: cover property (in_sleep && lv_event);
   c_ready: cover property (ready_event);
   c_external: cover property (analog.ext_sel && lv_event);
endmodule

// file: svm_analog_model.sv
// behavioural divider, reference and comparator beside the monitor
// assumes the tap code rises with threshold and supply is given as a code
module svm_analog_model (
   input wire logic mclk, // system clock
   input wire svm_pkg::svm_analog_t analog, // tap and power from block
   input wire logic [3:0] supply_lvl, // supply expressed as a tap code
   input wire logic ext_low, // external pin below reference
   output logic cmp_below // comparator output
);
   timeunit 1ns;
   timeprecision 1ps;
   initial cmp_below = 1'b0;
   // unpowered comparator gives junk, toggling so no lucky quiet line
   always @(posedge mclk) begin
      if (!analog.power) begin
         cmp_below <= !cmp_below;
      end else if (analog.ext_sel) begin
         cmp_below <= ext_low;
      end else begin
         cmp_below <= (analog.tap > supply_lvl);
      end
   end
endmodule

// file: tb_svm_ctrl.sv
// self-checking bench of the supply monitor control block
// assumes the register map and settle count of svm_pkg
module tb_svm_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, nrst, cmp_below, in_sleep, wake, irq, ext_low;
   logic [7:0] rdata;
   logic [3:0] supply_lvl;
   svm_pkg::svm_bus_req_t bus;
   svm_pkg::svm_analog_t analog;
   int fails = 0;
   int checks = 0;
   int cycles = 0;

   svm_ctrl svm_ctrl_i (.mclk(mclk), .nrst(nrst), .bus_req(bus), .rdata(rdata),
      .cmp_below(cmp_below), .in_sleep(in_sleep), .analog(analog), .wake(wake), .irq(irq));
   svm_analog_model svm_analog_model_i (.mclk(mclk), .analog(analog),
      .supply_lvl(supply_lvl), .ext_low(ext_low), .cmp_below(cmp_below));

   // free-running 50 MHz clock
   always #10 mclk = ~mclk;

   task automatic wrap_up();
      if (fails == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // hang guard: well above the one settle wait plus traffic
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("mismatch at %0t: run hung", $time);
         wrap_up();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe, released at the edge that takes it
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   task automatic t_reset();
      rdc(svm_pkg::OFS_CTRL, 8'h05);
      rdc(svm_pkg::OFS_IRQ_EN, 8'h00);
      rdc(svm_pkg::OFS_STATUS, 8'h00);
      rdc(4'h9, 8'h00);
      wr(svm_pkg::OFS_STATUS, 8'hFF);
      rdc(svm_pkg::OFS_STATUS, 8'h00);
      rdc(svm_pkg::OFS_CLEAR, 8'h00);
      chk({2'h0, analog}, 8'h05);
   endtask

   task automatic t_ext_settle();
      @(posedge mclk);
      ext_low <= 1'b1;
      wr(svm_pkg::OFS_CTRL, 8'hFF);
      rdc(svm_pkg::OFS_CTRL, 8'h1F);
      chk({2'h0, analog}, 8'h30);
      repeat (900) @(posedge mclk);
      rdc(svm_pkg::OFS_STATUS, 8'h00);
      repeat (200) @(posedge mclk);
      rdc(svm_pkg::OFS_CTRL, 8'h3F);
      rdc(svm_pkg::OFS_STATUS, 8'h03);
   endtask

   task automatic t_taps();
      @(posedge mclk);
      ext_low <= 1'b0;
      supply_lvl <= 4'hF;
      for (int c = 1; c < 15; c++) begin
         wr(svm_pkg::OFS_CTRL, 8'h10 | 8'(c));
         @(posedge mclk);
         #1 chk({2'h0, analog}, 8'h20 | 8'(c));
      end
   endtask

   task automatic t_flag();
      wr(svm_pkg::OFS_CTRL, 8'h18);
      repeat (3) @(posedge mclk);
      wr(svm_pkg::OFS_CLEAR, 8'h03);
      rdc(svm_pkg::OFS_STATUS, 8'h00);
      wr(svm_pkg::OFS_IRQ_EN, 8'h01);
      rdc(svm_pkg::OFS_IRQ_EN, 8'h01);
      chk({7'h0, irq}, 8'h00);
      @(posedge mclk);
      in_sleep <= 1'b1;
      supply_lvl <= 4'h7;
      repeat (4) @(posedge mclk);
      #1 chk({6'h0, wake, irq}, 8'h03);
      rdc(svm_pkg::OFS_STATUS, 8'h01);
      @(posedge mclk);
      supply_lvl <= 4'hF;
      in_sleep <= 1'b0;
      repeat (2) @(posedge mclk);
      wr(svm_pkg::OFS_CLEAR, 8'h01);
      @(posedge mclk);
      #1 chk({6'h0, wake, irq}, 8'h00);
      wr(svm_pkg::OFS_IRQ_EN, 8'h00);
      supply_lvl <= 4'h7;
      repeat (4) @(posedge mclk);
      #1 chk({7'h0, irq}, 8'h00);
      rdc(svm_pkg::OFS_STATUS, 8'h01);
   endtask

   task automatic t_power();
      wr(svm_pkg::OFS_CTRL, 8'h05);
      rdc(svm_pkg::OFS_CTRL, 8'h05);
      chk({2'h0, analog}, 8'h05);
      wr(svm_pkg::OFS_CTRL, 8'h15);
      repeat (100) @(posedge mclk);
      rdc(svm_pkg::OFS_CTRL, 8'h15);
   endtask

   task automatic t_mid_reset();
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      rdc(svm_pkg::OFS_CTRL, 8'h05);
      rdc(svm_pkg::OFS_IRQ_EN, 8'h00);
      chk({7'h0, irq}, 8'h00);
   endtask

   // main sequence
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      bus = '0;
      in_sleep = 1'b0;
      ext_low = 1'b0;
      supply_lvl = 4'hF;
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      t_ext_settle();
      t_taps();
      t_flag();
      t_power();
      t_mid_reset();
      wrap_up();
   end
endmodule
